//--- core/psq_int_ctrl.v
// Timed and event interrupt request latches
`timescale 1ns/1ps
`default_nettype none
`include "psq_regs.vh"

module psq_int_ctrl #(
  parameter [31:0] MS_CYC = `PSQ_MS_CYC
) (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Sources
  input wire tint_en_in,
  input wire [15:0] tint_period_in,
  input wire eint_en_in,
  input wire event_interrupt_in,
  // Service acknowledge
  input wire ack_t_in,
  input wire ack_e_in,
  // Pending and time base
  output reg pend_t_out,
  output reg pend_e_out,
  output reg ms_tick_out
);

  reg [31:0] ms_cnt_reg;
  reg [15:0] per_cnt_reg;
  reg ev_d_reg;
  wire per_hit;

  assign per_hit = ms_tick_out && tint_en_in && (tint_period_in != 16'h0000) &&
                   (per_cnt_reg + 16'h0001 >= tint_period_in);

  // ----------------------------------------
  // Time base, never stops while power is low
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      ms_cnt_reg <= 32'h00000000;
      per_cnt_reg <= 16'h0000;
      ms_tick_out <= 1'b0;
      ev_d_reg <= 1'b0;
      pend_t_out <= 1'b0;
      pend_e_out <= 1'b0;
    end else begin
      ms_tick_out <= (ms_cnt_reg == MS_CYC - 32'h00000001); // [R10]
      ms_cnt_reg <= (ms_cnt_reg == MS_CYC - 32'h00000001) ? 32'h00000000 :
                    ms_cnt_reg + 32'h00000001;
      if (per_hit) begin
        per_cnt_reg <= 16'h0000;
      end else if (ms_tick_out && tint_en_in) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
      ev_d_reg <= event_interrupt_in;
      // Set wins over the service clear
      pend_t_out <= per_hit | (pend_t_out & ~ack_t_in); // [R8]
      pend_e_out <= (event_interrupt_in & ~ev_d_reg & eint_en_in) |
                    (pend_e_out & ~ack_e_in); // [R8]
    end
  end

endmodule
`default_nettype wire

//--- core/psq_pwr_mon.v
// Momentary power failure classifier
`timescale 1ns/1ps
`default_nettype none
`include "psq_regs.vh"

module psq_pwr_mon #(
  parameter [31:0] LONG_CYC = `PSQ_PWR_LONG_CYC
) (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Supply monitor
  input wire power_fail_in,
  // To the sequencer
  output reg halt_out,
  output reg reinit_out
);

  reg [31:0] cnt_reg;
  reg long_reg;

  // ----------------------------------------
  // Failure duration measurement
  // ----------------------------------------
  // Long flag latches at the 20 ms mark; restore then asks for reinit
  always @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg <= 32'h00000000;
      long_reg <= 1'b0;
      halt_out <= 1'b0;
      reinit_out <= 1'b0;
    end else begin
      reinit_out <= 1'b0;
      if (power_fail_in) begin
        halt_out <= 1'b1; // [R9]
        if (!long_reg) begin
          cnt_reg <= cnt_reg + 32'h00000001;
          if (cnt_reg >= LONG_CYC - 32'h00000001) begin
            long_reg <= 1'b1; // [R12]
          end
        end
      end else begin
        halt_out <= 1'b0; // [R11]
        reinit_out <= long_reg; // [R12]
        long_reg <= 1'b0;
        cnt_reg <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

//--- core/psq_regs.vh
// Constants for the scan cycle sequencer
// Contract
// [R1] Initialization runs once after power-up or reset, before the first scan.
// [R2] Init resets I/O, self-diagnoses, clears volatile data, reads I/O configuration.
// [R3] Each scan first samples inputs into the input image area.
// [R4] Then the user program runs in order from step 0 to last step.
// [R5] After the last step the output image goes to the output modules.
// [R6] End phase: diagnosis, timer/counter update, network exchange, mode check.
// [R7] Interrupt suspends current work, runs its routine, resumes where stopped.
// [R8] Two interrupt sources: periodic timed and external event interrupt.
// [R9] Power loss under 20 ms halts the program, outputs held.
// [R10] Timers and timed interrupt time base keep running while halted.
// [R11] After a short power loss execution resumes without reinitializing.
// [R12] Power loss over 20 ms forces full initialization and restart.
// [R13] One scan spans step 0 to the next step 0.
// [R14] Scan time sums program, interrupt and internal processing time.
// [R15] Modes run, stop, pause, debug; changes checked only at scan end.
// [R16] Diagnosis flags scan time, memory, I/O, battery and power errors.
// [R17] Interrupts arriving during initialization wait until the first scan begins.
// [R18] After end processing the scan restarts at input refresh in run mode.
`ifndef PSQ_REGS_VH
`define PSQ_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSQ_CLK_MHZ 200
`define PSQ_PWR_LONG_MS 20
`define PSQ_PWR_LONG_CYC (`PSQ_PWR_LONG_MS * `PSQ_CLK_MHZ * 1000)
`define PSQ_MS_CYC (`PSQ_CLK_MHZ * 1000)
`define PSQ_SCAN_LIM_MS 200
`define PSQ_SCAN_LIM_CYC (`PSQ_SCAN_LIM_MS * `PSQ_CLK_MHZ * 1000)

// ----------------------------------------
// Task codes
// ----------------------------------------
`define PSQ_TK_IORST 4'h0
`define PSQ_TK_DIAG 4'h1
`define PSQ_TK_CLEAR 4'h2
`define PSQ_TK_CONFIG 4'h3
`define PSQ_TK_INREF 4'h4
`define PSQ_TK_STEP 4'h5
`define PSQ_TK_OUTREF 4'h6
`define PSQ_TK_TMRUPD 4'h7
`define PSQ_TK_NETX 4'h8
`define PSQ_TK_TINT 4'h9
`define PSQ_TK_EINT 4'hA

// ----------------------------------------
// Modes, error bits, reset values
// ----------------------------------------
`define PSQ_MODE_RUN 2'h0
`define PSQ_MODE_STOP 2'h1
`define PSQ_MODE_PAUSE 2'h2
`define PSQ_MODE_DEBUG 2'h3
`define PSQ_MODE_RST 2'h0
`define PSQ_ERR_SCAN 0
`define PSQ_ERR_DIAG_LSB 1
`define PSQ_ERR_RST 5'h00

`endif

//--- core/psq_scan_sequencer.v
// Scan cycle sequencer top level
`timescale 1ns/1ps
`default_nettype none
`include "psq_regs.vh"

module psq_scan_sequencer #(
  parameter [31:0] LONG_CYC = `PSQ_PWR_LONG_CYC,
  parameter [31:0] MS_CYC = `PSQ_MS_CYC,
  parameter [31:0] SCAN_LIM_CYC = `PSQ_SCAN_LIM_CYC
) (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Supply monitor
  input wire power_fail_in,
  // Mode selection
  input wire [1:0] mode_req_in,
  // Task handshake with executor
  input wire task_done_in,
  input wire [15:0] last_step_in,
  input wire [3:0] diag_err_in,
  // Interrupt sources
  input wire tint_en_in,
  input wire [15:0] tint_period_in,
  input wire eint_en_in,
  input wire event_interrupt_in,
  // Task requests
  output reg task_start_out,
  output reg [3:0] task_code_out,
  output reg [15:0] step_out,
  // Status
  output reg [6:0] state_out,
  output reg [1:0] mode_out,
  output reg [31:0] scan_time_out,
  output reg [4:0] err_out,
  output wire ms_tick_out
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [6:0] ST_INIT = 7'h01;
  localparam [6:0] ST_IN = 7'h02;
  localparam [6:0] ST_EXEC = 7'h04;
  localparam [6:0] ST_OUT = 7'h08;
  localparam [6:0] ST_END = 7'h10;
  localparam [6:0] ST_INT = 7'h20;
  localparam [6:0] ST_HALT = 7'h40;

  // ----------------------------------------
  // Registers and next values
  // ----------------------------------------
  reg [6:0] ret_reg;
  reg [6:0] ret_next;
  reg [6:0] state_next;
  reg [1:0] sub_reg;
  reg [1:0] sub_next;
  reg wait_reg;
  reg wait_next;
  reg start_next;
  reg [3:0] code_next;
  reg [15:0] step_next;
  reg [1:0] mode_next;
  reg ikind_reg;
  reg ikind_next;
  reg scan_on_reg;
  reg scan_on_next;
  reg stv_reg;
  reg stv_next;
  reg [31:0] cnt_reg;
  reg [31:0] cnt_next;
  reg [31:0] stime_next;
  reg [4:0] err_next;
  reg ack_t;
  reg ack_e;

  wire halt;
  wire reinit;
  wire pend_t;
  wire pend_e;
  wire scan_st;
  wire take_halt;
  wire take_int;
  wire run_mode;

  // ----------------------------------------
  // Power failure classifier
  // ----------------------------------------
  psq_pwr_mon #(
    .LONG_CYC(LONG_CYC)
  ) u_pwr (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .power_fail_in(power_fail_in),
    .halt_out(halt),
    .reinit_out(reinit)
  );

  // ----------------------------------------
  // Interrupt request latches and time base
  // ----------------------------------------
  psq_int_ctrl #(
    .MS_CYC(MS_CYC)
  ) u_int (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tint_en_in(tint_en_in),
    .tint_period_in(tint_period_in),
    .eint_en_in(eint_en_in),
    .event_interrupt_in(event_interrupt_in),
    .ack_t_in(ack_t),
    .ack_e_in(ack_e),
    .pend_t_out(pend_t),
    .pend_e_out(pend_e),
    .ms_tick_out(ms_tick_out)
  );

  // ----------------------------------------
  // Preemption decisions
  // ----------------------------------------
  // Only taken between tasks, so a running task is never cut in half
  assign scan_st = state_out[1] | state_out[2] | state_out[3] |
                   state_out[4];
  assign take_halt = halt & ~wait_reg & ~state_out[5] & ~state_out[6]; // [R9]
  assign take_int = scan_on_reg & (pend_t | pend_e) & ~wait_reg &
                    scan_st; // [R17]
  assign run_mode = (mode_out == `PSQ_MODE_RUN) ||
                    (mode_out == `PSQ_MODE_DEBUG);

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always @* begin
    state_next = state_out;
    ret_next = ret_reg;
    sub_next = sub_reg;
    wait_next = wait_reg;
    start_next = 1'b0;
    code_next = task_code_out;
    step_next = step_out;
    mode_next = mode_out;
    ikind_next = ikind_reg;
    scan_on_next = scan_on_reg;
    stv_next = stv_reg;
    stime_next = scan_time_out;
    err_next = err_out;
    ack_t = 1'b0;
    ack_e = 1'b0;
    // Halted time is not scan time; everything else counts until the count saturates at all ones
    cnt_next = (state_out == ST_HALT || cnt_reg == 32'hFFFFFFFF) ?
               cnt_reg : cnt_reg + 32'h00000001; // [R14]
    if (stv_reg && cnt_reg > SCAN_LIM_CYC) begin
      err_next[`PSQ_ERR_SCAN] = 1'b1; // [R16]
    end
    case (state_out)
      ST_INIT: begin
        if (wait_reg) begin
          if (task_done_in) begin
            wait_next = 1'b0;
            if (sub_reg == 2'h3) begin
              // Init done exactly once, go to first scan in run or debug mode, else to the end phase
              sub_next = 2'h0;
              state_next = run_mode ? ST_IN : ST_END; // [R1]
            end else begin
              sub_next = sub_reg + 2'h1;
            end
          end
        end else if (take_halt) begin
          ret_next = ST_INIT;
          state_next = ST_HALT;
        end else begin
          // I/O reset, diagnosis, clear, configuration in order
          start_next = 1'b1; // [R2]
          wait_next = 1'b1;
          code_next = {2'h0, sub_reg}; // [R2]
        end
      end
      ST_IN: begin
        if (wait_reg) begin
          if (task_done_in) begin
            wait_next = 1'b0;
            step_next = 16'h0000; // [R4]
            state_next = ST_EXEC;
          end
        end else if (take_halt) begin
          ret_next = ST_IN;
          state_next = ST_HALT;
        end else if (take_int) begin
          ret_next = ST_IN;
          state_next = ST_INT;
        end else begin
          start_next = 1'b1;
          wait_next = 1'b1;
          code_next = `PSQ_TK_INREF; // [R3]
          scan_on_next = 1'b1; // [R17]
        end
      end
      ST_EXEC: begin
        if (wait_reg) begin
          if (task_done_in) begin
            wait_next = 1'b0;
            if (step_out == last_step_in) begin
              state_next = ST_OUT; // [R5]
            end else begin
              step_next = step_out + 16'h0001; // [R4]
            end
          end
        end else if (take_halt) begin
          ret_next = ST_EXEC;
          state_next = ST_HALT;
        end else if (take_int) begin
          ret_next = ST_EXEC;
          state_next = ST_INT;
        end else begin
          start_next = 1'b1;
          wait_next = 1'b1;
          code_next = `PSQ_TK_STEP; // [R4]
          if (step_out == 16'h0000) begin
            // Step 0 closes one scan and opens the next
            if (stv_reg) begin
              stime_next = cnt_reg; // [R13]
            end
            stv_next = 1'b1;
            cnt_next = 32'h00000001; // [R13]
          end
        end
      end
      ST_OUT: begin
        if (wait_reg) begin
          if (task_done_in) begin
            wait_next = 1'b0;
            sub_next = 2'h0;
            state_next = ST_END;
          end
        end else if (take_halt) begin
          ret_next = ST_OUT;
          state_next = ST_HALT;
        end else if (take_int) begin
          ret_next = ST_OUT;
          state_next = ST_INT;
        end else begin
          start_next = 1'b1;
          wait_next = 1'b1;
          code_next = `PSQ_TK_OUTREF; // [R5]
        end
      end
      ST_END: begin
        if (wait_reg) begin
          if (task_done_in) begin
            wait_next = 1'b0;
            sub_next = sub_reg + 2'h1;
            if (sub_reg == 2'h0) begin
              err_next[4:1] = err_out[4:1] | diag_err_in; // [R16]
            end
          end
        end else if (take_halt) begin
          ret_next = ST_END;
          state_next = ST_HALT;
        end else if (take_int) begin
          ret_next = ST_END;
          state_next = ST_INT;
        end else if (sub_reg == 2'h3) begin
          // Mode is sampled here and nowhere else
          mode_next = mode_req_in; // [R15]
          sub_next = 2'h0;
          if (mode_req_in == `PSQ_MODE_RUN ||
              mode_req_in == `PSQ_MODE_DEBUG) begin
            state_next = ST_IN; // [R18]
          end
        end else begin
          start_next = 1'b1;
          wait_next = 1'b1;
          case (sub_reg)
            2'h0: code_next = `PSQ_TK_DIAG; // [R6]
            2'h1: code_next = `PSQ_TK_TMRUPD; // [R6]
            default: code_next = `PSQ_TK_NETX; // [R6]
          endcase
        end
      end
      ST_INT: begin
        if (wait_reg) begin
          if (task_done_in) begin
            wait_next = 1'b0;
            state_next = ret_reg; // [R7]
          end
        end else begin
          // Timed source has priority over the event source
          start_next = 1'b1;
          wait_next = 1'b1;
          if (pend_t) begin
            ikind_next = 1'b1;
            ack_t = 1'b1;
            code_next = `PSQ_TK_TINT; // [R7]
          end else begin
            ikind_next = 1'b0;
            ack_e = 1'b1;
            code_next = `PSQ_TK_EINT; // [R7]
          end
        end
      end
      ST_HALT: begin
        // Outputs stay as last refreshed; reinit beats resume
        if (reinit) begin
          state_next = ST_INIT; // [R12]
          sub_next = 2'h0;
          step_next = 16'h0000;
          scan_on_next = 1'b0;
          stv_next = 1'b0;
          cnt_next = 32'h00000000;
        end else if (!halt) begin
          state_next = ret_reg; // [R11]
        end
      end
      default: begin
        state_next = ST_INIT;
        sub_next = 2'h0;
        wait_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      state_out <= ST_INIT; // [R1]
      ret_reg <= ST_INIT;
      sub_reg <= 2'h0;
      wait_reg <= 1'b0;
      task_start_out <= 1'b0;
      task_code_out <= `PSQ_TK_IORST;
      step_out <= 16'h0000;
      mode_out <= `PSQ_MODE_RST;
      ikind_reg <= 1'b0;
      scan_on_reg <= 1'b0;
      stv_reg <= 1'b0;
      cnt_reg <= 32'h00000000;
      scan_time_out <= 32'h00000000;
      err_out <= `PSQ_ERR_RST;
    end else begin
      state_out <= state_next;
      ret_reg <= ret_next;
      sub_reg <= sub_next;
      wait_reg <= wait_next;
      task_start_out <= start_next;
      task_code_out <= code_next;
      step_out <= step_next;
      mode_out <= mode_next;
      ikind_reg <= ikind_next;
      scan_on_reg <= scan_on_next;
      stv_reg <= stv_next;
      cnt_reg <= cnt_next;
      scan_time_out <= stime_next;
      err_out <= err_next;
    end
  end

endmodule
`default_nettype wire

//--- tb/psq_checker.sv
// Assertion checker bound to the scan cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_checker #(
  parameter [31:0] LONG_CYC = 32'h0000_00C8,
  parameter [31:0] MS_CYC = 32'h0000_0014,
  parameter [31:0] SCAN_LIM_CYC = 32'h0000_1388
) (
  // Design inputs
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic power_fail_in,
  input wire logic task_done_in,
  input wire logic [15:0] last_step_in,
  // Design outputs
  input wire logic task_start_out,
  input wire logic [3:0] task_code_out,
  input wire logic [15:0] step_out,
  input wire logic [6:0] state_out,
  input wire logic [1:0] mode_out
);
  logic [6:0] saved_reg;
  logic [31:0] fail_cnt_reg;
  // ----------------------------------------
  // State to come back to, length of supply loss
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      saved_reg <= 7'h01;
      fail_cnt_reg <= 32'h0000_0000;
    end else begin
      if (state_out != 7'h20 && state_out != 7'h40) saved_reg <= state_out;
      fail_cnt_reg <= power_fail_in ? fail_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Done of a given task in a given phase
  sequence s_done(logic [6:0] st, logic [3:0] c);
    task_done_in && state_out == st && task_code_out == c;
  endsequence
  a_init_first: assert property (
    $fell(srst_in) |-> ##[0:1] (task_start_out && task_code_out == 4'h0))
    else $error("init does not open with module reset");
  a_step_zero: assert property (
    s_done(7'h02, 4'h4) |=> ##1 !task_start_out || (task_code_out == 4'h5 && step_out == 16'h0))
    else $error("program does not start at step 0");
  a_step_next: assert property (
    s_done(7'h04, 4'h5) ##0 step_out != last_step_in |=> ##1 !task_start_out ||
      (task_code_out == 4'h5 && step_out == $past(step_out, 2) + 16'h0001))
    else $error("step order broken");
  a_out_after_last: assert property (
    s_done(7'h04, 4'h5) ##0 step_out == last_step_in |=> ##1 !task_start_out ||
      task_code_out == 4'h6)
    else $error("no output refresh after last step");
  a_end_exit: assert property (
    s_done(7'h10, 4'h8) |=> !task_start_out ##1 !task_start_out ##1
      (!task_start_out || task_code_out inside {4'h9, 4'hA} ||
      task_code_out == (mode_out inside {2'h0, 2'h3} ? 4'h4 : 4'h1)))
    else $error("wrong exit from end phase");
  a_mode_at_end: assert property (
    $changed(mode_out) |-> $past(state_out) == 7'h10)
    else $error("mode changed outside end phase");
  a_int_entry: assert property (
    $rose(state_out == 7'h20) |=> task_start_out && task_code_out inside {4'h9, 4'hA})
    else $error("no routine after interrupt entry");
  a_int_return: assert property (
    state_out == 7'h20 && task_done_in |=> state_out == saved_reg)
    else $error("interrupt did not return");
  a_halt_quiet: assert property (
    state_out == 7'h40 |-> !task_start_out && $stable(task_code_out) && $stable(step_out))
    else $error("activity while halted");
  a_short_resume: assert property (
    $fell(power_fail_in) && state_out == 7'h40 && fail_cnt_reg < LONG_CYC |->
      ##[1:3] state_out == saved_reg)
    else $error("no resume after short loss");
  a_long_reinit: assert property (
    $fell(power_fail_in) && fail_cnt_reg >= LONG_CYC |-> ##[1:3] state_out == 7'h01)
    else $error("no reinit after long loss");
endmodule
bind psq_scan_sequencer psq_checker #(.LONG_CYC(LONG_CYC), .MS_CYC(MS_CYC),
  .SCAN_LIM_CYC(SCAN_LIM_CYC)) u_psq_checker (.clk_in(clk_in), .srst_in(srst_in),
  .power_fail_in(power_fail_in), .task_done_in(task_done_in), .last_step_in(last_step_in),
  .task_start_out(task_start_out), .task_code_out(task_code_out), .step_out(step_out),
  .state_out(state_out), .mode_out(mode_out));
`default_nettype wire

//--- tb/psq_exec_model.sv
// Behavioural task executor that answers the sequencer's requests
`timescale 1ns/1ps
`default_nettype none
module psq_exec_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Request and answer
  input wire logic task_start_in,
  input wire logic [15:0] delay_in,
  output logic task_done_out = 1'b0
);
  logic busy_reg;
  logic [15:0] cnt_reg;
  // One done pulse per request; never a done with nothing outstanding
  always @(posedge clk_in) begin
    task_done_out <= 1'b0;
    if (srst_in) begin
      busy_reg <= 1'b0;
    end else if (task_start_in) begin
      busy_reg <= 1'b1;
      cnt_reg <= delay_in;
    end else if (busy_reg && cnt_reg == 16'h0000) begin
      busy_reg <= 1'b0;
      task_done_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the scan cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Shortened counts: 200 cycles is a long loss, 20 cycles a millisecond
  localparam logic [31:0] LONG = 32'h0000_00C8;
  localparam logic [31:0] MSC = 32'h0000_0014;
  localparam logic [31:0] LIM = 32'h0000_1388;
  logic clk_in = 1'b0, srst_in = 1'b1, power_fail_in = 1'b0, big = 1'b0;
  logic tint_en_in = 1'b0, eint_en_in = 1'b1, event_interrupt_in = 1'b0;
  logic [1:0] mode_req_in = 2'h0;
  logic [3:0] diag_err_in = 4'h0;
  logic [15:0] last_step_in = 16'h0000, delay = 16'h0000, tint_period = 16'h0001;
  wire task_done_in, task_start_out, ms_tick_out;
  wire [3:0] task_code_out;
  wire [15:0] step_out;
  wire [6:0] state_out;
  wire [1:0] mode_out;
  wire [31:0] scan_time_out;
  wire [4:0] err_out;
  integer seed = 32'hbc09, n_errors = 0, num_checks = 0, cyc = 0, ticks = 0, pend = 0;
  logic [3:0] codes[$];
  logic [15:0] steps[$];
  integer s0_t[$];
  logic [31:0] st_q[$];
  psq_scan_sequencer #(.LONG_CYC(LONG), .MS_CYC(MSC), .SCAN_LIM_CYC(LIM)) u_psq_scan_sequencer (
    .clk_in(clk_in), .srst_in(srst_in), .power_fail_in(power_fail_in),
    .mode_req_in(mode_req_in), .task_done_in(task_done_in), .last_step_in(last_step_in),
    .diag_err_in(diag_err_in), .tint_en_in(tint_en_in), .tint_period_in(tint_period),
    .eint_en_in(eint_en_in), .event_interrupt_in(event_interrupt_in),
    .task_start_out(task_start_out), .task_code_out(task_code_out), .step_out(step_out),
    .state_out(state_out), .mode_out(mode_out), .scan_time_out(scan_time_out),
    .err_out(err_out), .ms_tick_out(ms_tick_out));
  psq_exec_model u_psq_exec_model (.clk_in(clk_in), .srst_in(srst_in),
    .task_start_in(task_start_out), .delay_in(delay), .task_done_out(task_done_in));
  // 200 MHz clock
  initial forever #2.5 clk_in = ~clk_in;
  // Executor latency: random 0..3, or one very slow task
  always @(negedge clk_in) delay <= big ? 16'h1400 : 16'($random(seed) & 32'h3);
  // ----------------------------------------
  // Monitor: requests, step-0 times, reported scan time
  // ----------------------------------------
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    ticks <= ticks + (ms_tick_out === 1'b1);
    pend <= (pend > 0) ? pend - 1 : 0;
    if (pend == 1) st_q.push_back(scan_time_out);
    if (task_start_out === 1'b1) begin
      codes.push_back(task_code_out);
      steps.push_back(step_out);
      if (task_code_out === 4'h5 && step_out === 16'h0000) begin
        s0_t.push_back(cyc);
        pend <= 3;
      end
    end
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_flag(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic idle(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  // First request with code c at or after index from, else -1
  function automatic integer find(input logic [3:0] c, input integer from);
    find = -1;
    for (integer i = codes.size() - 1; i >= from; i--) if (codes[i] === c) find = i;
  endfunction
  // Request k of a clean scan whose last step is l
  function automatic logic [3:0] exp_code(input integer k, input integer l);
    if (k == 0) exp_code = 4'h4;
    else if (k <= l + 1) exp_code = 4'h5;
    else if (k == l + 2) exp_code = 4'h6;
    else exp_code = (k == l + 3) ? 4'h1 : ((k == l + 4) ? 4'h7 : 4'h8);
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    integer l, i, j, m;
    l = $random(seed) & 3;
    last_step_in = 16'(l);
    idle(20);
    srst_in = 1'b0;
    idle(3);
    event_interrupt_in = 1'b1; // Edge lands during init, must wait
    idle(2);
    event_interrupt_in = 1'b0;
    idle(400);
    for (i = 0; i < 4; i++) chk_val(codes[i], i, "init order");
    chk_flag(find(4'hA, 0) > find(4'h4, 0) && find(4'h4, 0) > 3, "held event");
    i = find(4'h4, find(4'h4, find(4'h4, 0) + 1) + 1);
    j = find(4'h4, i + 1);
    chk_val(j - i, l + 6, "scan length");
    for (m = 0; m < l + 6; m++) chk_val(codes[i + m], exp_code(m, l), "order");
    for (m = 1; m <= l + 1; m++) chk_val(steps[i + m], m - 1, "step index");
    tint_period = 16'(($random(seed) & 3) + 1);
    tint_en_in = 1'b1;
    repeat (300) begin
      @(negedge clk_in);
      event_interrupt_in = ($random(seed) & 7) == 0;
    end
    event_interrupt_in = 1'b0;
    tint_en_in = 1'b0;
    eint_en_in = 1'b0;
    idle(60);
    chk_flag(find(4'h9, j) >= 0 && find(4'hA, j) >= 0, "both interrupts");
    i = codes.size();
    event_interrupt_in = 1'b1;
    idle(60);
    event_interrupt_in = 1'b0;
    chk_flag(find(4'hA, i) < 0, "event masked");
    for (m = 1; m < st_q.size(); m++) chk_val(st_q[m], s0_t[m] - s0_t[m - 1], "scan time");
    for (m = 3; m >= 0; m--) begin
      mode_req_in = 2'(m);
      idle(150);
      i = codes.size();
      idle(100);
      chk_val(mode_out, m, "mode");
      chk_flag((find(4'h5, i) >= 0) == (m == 0 || m == 3), "program runs");
    end
    i = ($random(seed) & 15) | 1;
    diag_err_in = 4'(i);
    idle(100);
    diag_err_in = 4'h0;
    idle(100);
    chk_val(err_out, {i[3:0], 1'b0}, "diag flags");
    big = 1'b1;
    idle(8);
    big = 1'b0;
    idle(12000);
    chk_val(err_out[0], 1, "scan over limit");
    power_fail_in = 1'b1;
    idle(20);
    chk_val(state_out, 7'h40, "halted");
    i = codes.size();
    j = ticks;
    idle(30);
    chk_val(codes.size(), i, "quiet in halt");
    chk_flag(ticks - j >= 1, "time base runs");
    power_fail_in = 1'b0;
    idle(40);
    chk_flag(find(4'h0, i) < 0 && codes.size() > i, "resume");
    power_fail_in = 1'b1;
    idle(250);
    power_fail_in = 1'b0;
    idle(40);
    chk_flag(find(4'h0, i) >= 0, "reinit");
    end_sim;
  end
endmodule
`default_nettype wire
